// ===== shared/avi_cfg.svh
// register indices, field positions and constants for the packet status bank
`ifndef AVI_CFG_SVH
`define AVI_CFG_SVH

`define AVI_ADDR_W 12
`define AVI_IDX_W 10
`define AVI_FLAG_W 7

// register indices, byte address is four times the index
`define AVI_IDX_SCALING 10'h083
`define AVI_IDX_VFC 10'h084
`define AVI_IDX_PREP 10'h085
`define AVI_IDX_TOP_LO 10'h086
`define AVI_IDX_FLAGS_A 10'h087
`define AVI_IDX_TOP_HI 10'h088
`define AVI_IDX_BOT_LO 10'h089
`define AVI_IDX_BOT_HI 10'h08A
`define AVI_IDX_LEFT_LO 10'h08B
`define AVI_IDX_LEFT_HI 10'h08C
`define AVI_IDX_RIGHT_LO 10'h08D
`define AVI_IDX_RIGHT_HI 10'h08E
`define AVI_IDX_FLAGS_B 10'h08F
`define AVI_IDX_SHAPE 10'h0C0
`define AVI_IDX_ISTAT 10'h0C1
`define AVI_IDX_MASK 10'h0C2

// flag bit positions
`define AVI_FLAG_AVI 0
`define AVI_FLAG_AUDIO 1
`define AVI_FLAG_SPD 2
`define AVI_FLAG_MPEG 3
`define AVI_FLAG_ACP 4
`define AVI_FLAG_TRK1 5
`define AVI_FLAG_TRK2 6

// framing shape codes
`define AVI_AR_SAME 4'h8
`define AVI_AR_4_3 4'h9
`define AVI_AR_16_9 4'hA
`define AVI_AR_14_9 4'hB

// scaling codes
`define AVI_SCALE_NONE 2'h0
`define AVI_SCALE_HORIZ 2'h1
`define AVI_SCALE_VERT 2'h2
`define AVI_SCALE_BOTH 2'h3

// pixel repetition, highest valid code
`define AVI_PREP_MAX 4'h9

// reset and empty values
`define AVI_FLAGS_NONE 7'h00
`define AVI_RST_4 4'h0
`define AVI_RST_2 2'h0
`define AVI_RST_7 7'h00
`define AVI_RST_16 16'h0000
`define AVI_RST_32 32'h0000_0000

`endif

// ===== shared/avi_pkg.sv
// types of the packet status bank
`default_nettype none
package avi_pkg;

    typedef struct packed {
        logic [6:0] bits;
    } avi_flag_t;

    typedef struct packed {
        logic [3:0] shape;
        logic [1:0] scaling;
        logic [6:0] vfc;
        logic [3:0] prep;
        logic [15:0] top;
        logic [15:0] bottom;
        logic [15:0] left;
        logic [15:0] right;
        logic [6:0] mask;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } avi_regs_t;

endpackage
`default_nettype wire

// ===== rtl/avi_flag_tracker.sv
// sticky flag set: event pulses set bits, a clear empties it, set wins
`default_nettype none
`include "avi_cfg.svh"
module avi_flag_tracker
    import avi_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic [6:0] set_bits,
    input wire logic clear,
    // state
    output logic [6:0] flags
);

    avi_flag_t s;
    avi_flag_t next_s;

    always_comb begin
        next_s = s;
        if (clear) begin
            next_s.bits = `AVI_FLAGS_NONE;
        end
        // an event in the clearing cycle survives
        next_s.bits = next_s.bits | set_bits;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.bits <= `AVI_FLAGS_NONE;
        end else begin
            s <= next_s;
        end
    end

    assign flags = s.bits;

endmodule
`default_nettype wire

// ===== rtl/avi_status_regs.sv
// status register bank for decoded video info packets, APB slave
//
// What this block does
// - the 4-bit framing shape code is kept as received, 8 same as picture, 9 4:3, A 16:9, B 14:9 centred.
// - the 2-bit scaling code reads in the low bits of the register at index 0x83.
// - the 7-bit video format code reads in the low seven bits of the register at index 0x84.
// - the 4-bit pixel repetition value N reads at index 0x85, codes 0 to 9 valid and A to F reserved.
// - the top bar end line is 16 bits, low byte at index 0x86 and high byte at 0x88, zero means no bar.
// - the lower bar start line is 16 bits, low byte at index 0x89 and high byte at 0x8A.
// - the left bar last pixel is 16 bits, low byte at index 0x8B and high byte at 0x8C.
// - the right bar first pixel is 16 bits, low byte at index 0x8D and high byte at 0x8E.
// - a changed-packet flag sets when the content of its packet type changes and all read zero otherwise.
// - a read of either flag register clears every flag in both copies; a flag whose event arrives in the reading cycle stays set.
// - both flag registers, at 0x87 and 0x8F, return the same flag contents.
// - the flag field is seven bits, one for each of the seven packet types.
//
// Added by the designer: the APB register port.
`default_nettype none
`include "avi_cfg.svh"
module avi_status_regs
    import avi_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // decoded video info packet
    input wire logic avi_valid,
    input wire logic [3:0] avi_shape,
    input wire logic [1:0] avi_scaling,
    input wire logic [6:0] avi_vfc,
    input wire logic [3:0] avi_prep,
    input wire logic [15:0] avi_top,
    input wire logic [15:0] avi_bottom,
    input wire logic [15:0] avi_left,
    input wire logic [15:0] avi_right,
    // change pulses of the other packet types, flag bits 6 to 1
    input wire logic [6:1] other_changed,
    // interrupt
    output logic irq
);

    avi_regs_t s;
    avi_regs_t next_s;
    logic [6:0] flags;
    logic [6:0] istat;
    logic [6:0] events;
    logic [9:0] idx;
    logic acc;
    logic rd_acc;
    logic wr_acc;
    logic avi_change;
    logic flags_rd;
    logic istat_rd;

    // register read mux, bit 32 flags an unmapped address
    function automatic logic [32:0] rd_word(
        input logic [9:0] i,
        input logic [1:0] lo,
        input avi_regs_t r,
        input logic [6:0] f,
        input logic [6:0] st
    );
        logic [32:0] w;
        w = {1'b0, `AVI_RST_32};
        if (lo != 2'h0) begin
            w[32] = 1'b1;
        end else if (i == `AVI_IDX_SCALING) begin
            w[1:0] = r.scaling;
        end else if (i == `AVI_IDX_VFC) begin
            w[6:0] = r.vfc;
        end else if (i == `AVI_IDX_PREP) begin
            w[3:0] = r.prep;
        end else if (i == `AVI_IDX_TOP_LO) begin
            w[7:0] = r.top[7:0];
        end else if (i == `AVI_IDX_TOP_HI) begin
            w[7:0] = r.top[15:8];
        end else if (i == `AVI_IDX_BOT_LO) begin
            w[7:0] = r.bottom[7:0];
        end else if (i == `AVI_IDX_BOT_HI) begin
            w[7:0] = r.bottom[15:8];
        end else if (i == `AVI_IDX_LEFT_LO) begin
            w[7:0] = r.left[7:0];
        end else if (i == `AVI_IDX_LEFT_HI) begin
            w[7:0] = r.left[15:8];
        end else if (i == `AVI_IDX_RIGHT_LO) begin
            w[7:0] = r.right[7:0];
        end else if (i == `AVI_IDX_RIGHT_HI) begin
            w[7:0] = r.right[15:8];
        end else if (i == `AVI_IDX_FLAGS_A || i == `AVI_IDX_FLAGS_B) begin
            w[6:0] = f;
        end else if (i == `AVI_IDX_SHAPE) begin
            w[3:0] = r.shape;
        end else if (i == `AVI_IDX_ISTAT) begin
            w[6:0] = st;
        end else if (i == `AVI_IDX_MASK) begin
            w[6:0] = r.mask;
        end else begin
            w[32] = 1'b1;
        end
        return w;
    endfunction

    assign idx = paddr[11:2];
    // one wait state: the answer is prepared in the first access cycle
    assign acc = psel && penable && !s.pready;
    assign rd_acc = acc && !pwrite;
    assign wr_acc = acc && pwrite;

    // video info content differs from what is held
    assign avi_change = avi_valid && ({avi_shape, avi_scaling, avi_vfc, avi_prep,
        avi_top, avi_bottom, avi_left, avi_right} != {s.shape, s.scaling, s.vfc,
        s.prep, s.top, s.bottom, s.left, s.right});
    assign events = {other_changed, avi_change};

    // the read returns the old flags while the same edge clears them
    assign flags_rd = rd_acc && paddr[1:0] == 2'h0 &&
        (idx == `AVI_IDX_FLAGS_A || idx == `AVI_IDX_FLAGS_B);
    assign istat_rd = rd_acc && paddr[1:0] == 2'h0 && idx == `AVI_IDX_ISTAT;

    avi_flag_tracker u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(events),
        .clear(flags_rd),
        .flags(flags)
    );

    avi_flag_tracker u_istat (
        .pclk(pclk),
        .presetn(presetn),
        .set_bits(events),
        .clear(istat_rd),
        .flags(istat)
    );

    always_comb begin
        logic [32:0] w;
        w = rd_word(idx, paddr[1:0], s, flags, istat);
        next_s = s;
        next_s.pready = acc;
        next_s.pslverr = acc && w[32];
        if (rd_acc) begin
            next_s.prdata = w[31:0];
        end
        // only the mask takes writes, read-only registers ignore them
        if (wr_acc && !w[32] && idx == `AVI_IDX_MASK) begin
            next_s.mask = pwdata[6:0];
        end
        if (avi_valid) begin
            next_s.shape = avi_shape;
            next_s.scaling = avi_scaling;
            next_s.vfc = avi_vfc;
            next_s.prep = avi_prep;
            next_s.top = avi_top;
            next_s.bottom = avi_bottom;
            next_s.left = avi_left;
            next_s.right = avi_right;
        end
        next_s.irq = |(istat & s.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.shape <= `AVI_RST_4;
            s.scaling <= `AVI_RST_2;
            s.vfc <= `AVI_RST_7;
            s.prep <= `AVI_RST_4;
            s.top <= `AVI_RST_16;
            s.bottom <= `AVI_RST_16;
            s.left <= `AVI_RST_16;
            s.right <= `AVI_RST_16;
            s.mask <= `AVI_FLAGS_NONE;
            s.pready <= 1'b0;
            s.pslverr <= 1'b0;
            s.prdata <= `AVI_RST_32;
            s.irq <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_pready;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_pready: assert property (p_pready) else $error("pready not one cycle after access");

    property p_flag_set;
        avi_change |=> flags[`AVI_FLAG_AVI];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("video info change not flagged");

    property p_flag_clear;
        flags_rd && other_changed == 6'h00 && !avi_change |=> flags == `AVI_FLAGS_NONE;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag read did not clear");

    property p_flag_copy;
        flags_rd |=> prdata[6:0] == $past(flags) && prdata[31:7] == 25'h0;
    endproperty
    a_flag_copy: assert property (p_flag_copy) else $error("flag copy mismatch");

    property p_other_bits;
        other_changed[`AVI_FLAG_TRK2] |=> flags[`AVI_FLAG_TRK2] && istat[`AVI_FLAG_TRK2];
    endproperty
    a_other_bits: assert property (p_other_bits) else $error("track code flag not at bit 6");

    property p_vfc_read;
        rd_acc && paddr == {`AVI_IDX_VFC, 2'h0} |=> prdata == {25'h0, $past(s.vfc)};
    endproperty
    a_vfc_read: assert property (p_vfc_read) else $error("video format code read wrong");

    property p_top_read;
        rd_acc && paddr == {`AVI_IDX_TOP_HI, 2'h0} |=> prdata == {24'h0, $past(s.top[15:8])};
    endproperty
    a_top_read: assert property (p_top_read) else $error("top bar high byte wrong");

    property p_right_read;
        rd_acc && paddr == {`AVI_IDX_RIGHT_LO, 2'h0} |=> prdata == {24'h0, $past(s.right[7:0])};
    endproperty
    a_right_read: assert property (p_right_read) else $error("right bar low byte wrong");

    property p_ro_write;
        wr_acc && idx != `AVI_IDX_MASK && !avi_valid |=> $stable(s.vfc) && $stable(s.top) && $stable(s.mask);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("write changed read-only state");

    property p_capture;
        avi_valid |=> s.shape == $past(avi_shape) && s.prep == $past(avi_prep) &&
            s.scaling == $past(avi_scaling);
    endproperty
    a_capture: assert property (p_capture) else $error("packet fields not captured");

    property p_irq;
        |(istat & s.mask) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked status without interrupt");

    property p_unmapped;
        acc && paddr == {10'h3FF, 2'h0} |=> pslverr && pready;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address not refused");

    property p_shape_read;
        rd_acc && paddr == {`AVI_IDX_SHAPE, 2'h0} |=> prdata == {28'h0, $past(s.shape)};
    endproperty
    a_shape_read: assert property (p_shape_read) else $error("framing shape code read wrong");

    property p_scaling_read;
        rd_acc && paddr == {`AVI_IDX_SCALING, 2'h0} |=> prdata == {30'h0, $past(s.scaling)};
    endproperty
    a_scaling_read: assert property (p_scaling_read) else $error("scaling code read wrong");

    property p_prep_read;
        rd_acc && paddr == {`AVI_IDX_PREP, 2'h0} |=> prdata == {28'h0, $past(s.prep)};
    endproperty
    a_prep_read: assert property (p_prep_read) else $error("pixel repetition read wrong");

    property p_top_lo_read;
        rd_acc && paddr == {`AVI_IDX_TOP_LO, 2'h0} |=> prdata == {24'h0, $past(s.top[7:0])};
    endproperty
    a_top_lo_read: assert property (p_top_lo_read) else $error("top bar low byte wrong");

    property p_bot_lo_read;
        rd_acc && paddr == {`AVI_IDX_BOT_LO, 2'h0} |=> prdata == {24'h0, $past(s.bottom[7:0])};
    endproperty
    a_bot_lo_read: assert property (p_bot_lo_read) else $error("lower bar low byte wrong");

    property p_bot_hi_read;
        rd_acc && paddr == {`AVI_IDX_BOT_HI, 2'h0} |=> prdata == {24'h0, $past(s.bottom[15:8])};
    endproperty
    a_bot_hi_read: assert property (p_bot_hi_read) else $error("lower bar high byte wrong");

    property p_left_lo_read;
        rd_acc && paddr == {`AVI_IDX_LEFT_LO, 2'h0} |=> prdata == {24'h0, $past(s.left[7:0])};
    endproperty
    a_left_lo_read: assert property (p_left_lo_read) else $error("left bar low byte wrong");

    property p_left_hi_read;
        rd_acc && paddr == {`AVI_IDX_LEFT_HI, 2'h0} |=> prdata == {24'h0, $past(s.left[15:8])};
    endproperty
    a_left_hi_read: assert property (p_left_hi_read) else $error("left bar high byte wrong");

    property p_right_hi_read;
        rd_acc && paddr == {`AVI_IDX_RIGHT_HI, 2'h0} |=> prdata == {24'h0, $past(s.right[15:8])};
    endproperty
    a_right_hi_read: assert property (p_right_hi_read) else $error("right bar high byte wrong");

    property p_capture_bars;
        avi_valid |=> s.top == $past(avi_top) && s.bottom == $past(avi_bottom) &&
            s.left == $past(avi_left) && s.right == $past(avi_right);
    endproperty
    a_capture_bars: assert property (p_capture_bars) else $error("bar fields not captured");

    property p_flag_hold;
        !flags_rd && events == `AVI_FLAGS_NONE |=> flags == $past(flags);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flags moved without event or read");

    property p_istat_clear;
        istat_rd && events == `AVI_FLAGS_NONE |=> istat == `AVI_FLAGS_NONE;
    endproperty
    a_istat_clear: assert property (p_istat_clear) else $error("status read did not clear");

    property p_ro_no_err;
        wr_acc && paddr == {`AVI_IDX_SCALING, 2'h0} |=> pready && !pslverr;
    endproperty
    a_ro_no_err: assert property (p_ro_no_err) else $error("read-only write refused");

    property p_mask_write;
        wr_acc && paddr == {`AVI_IDX_MASK, 2'h0} |=> s.mask == $past(pwdata[6:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    property p_flag_write;
        wr_acc && events == `AVI_FLAGS_NONE |=> flags == $past(flags) && istat == $past(istat);
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("write changed flags");

    c_flag_read: cover property (flags_rd && flags != `AVI_FLAGS_NONE);
    c_avi_change: cover property (avi_change ##[1:20] flags_rd);
    c_irq: cover property (!irq ##1 irq);
    c_reserved_pr: cover property (avi_valid && avi_prep > `AVI_PREP_MAX);
    c_ro_write: cover property (wr_acc && idx != `AVI_IDX_MASK);

endmodule
`default_nettype wire

// ===== test/avi_src_model.sv
// behavioural video source presenting decoded packet fields and change pulses
`default_nettype none
module avi_src_model (
    // clock
    input wire logic pclk,
    // decoded video info packet
    output logic avi_valid,
    output logic [3:0] avi_shape,
    output logic [1:0] avi_scaling,
    output logic [6:0] avi_vfc,
    output logic [3:0] avi_prep,
    output logic [15:0] avi_top,
    output logic [15:0] avi_bottom,
    output logic [15:0] avi_left,
    output logic [15:0] avi_right,
    // change pulses of the other packet types
    output logic [6:1] other_changed
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        avi_valid = 1'b0;
        {avi_shape, avi_scaling, avi_vfc, avi_prep} = 17'h00000;
        {avi_top, avi_bottom, avi_left, avi_right} = 64'h0;
        other_changed = 6'h00;
    end
    // fields are inverted once valid drops so nothing stale looks right
    task send(input logic [3:0] sh, input logic [1:0] sc, input logic [6:0] vc, input logic [3:0] rp,
              input logic [63:0] bars);
        @(posedge pclk);
        avi_valid <= 1'b1;
        {avi_shape, avi_scaling, avi_vfc, avi_prep} <= {sh, sc, vc, rp};
        {avi_top, avi_bottom, avi_left, avi_right} <= bars;
        @(posedge pclk);
        avi_valid <= 1'b0;
        {avi_shape, avi_scaling, avi_vfc, avi_prep} <= ~{sh, sc, vc, rp};
        {avi_top, avi_bottom, avi_left, avi_right} <= ~bars;
    endtask
    task pulse(input logic [6:1] b);
        @(posedge pclk);
        other_changed <= b;
        @(posedge pclk);
        other_changed <= 6'h00;
    endtask
endmodule
`default_nettype wire

// ===== test/avi_status_regs_tb.sv
// self-checking bench of the packet status register bank
`default_nettype none
`include "avi_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module avi_status_regs_tb import avi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, avi_valid, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] avi_shape, avi_prep;
    logic [1:0] avi_scaling;
    logic [6:0] avi_vfc;
    logic [15:0] avi_top, avi_bottom, avi_left, avi_right;
    logic [6:1] other_changed;
    int num_errors = 0;
    int n_checks = 0;
    avi_status_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .avi_valid(avi_valid), .avi_shape(avi_shape), .avi_scaling(avi_scaling), .avi_vfc(avi_vfc),
        .avi_prep(avi_prep), .avi_top(avi_top), .avi_bottom(avi_bottom), .avi_left(avi_left),
        .avi_right(avi_right), .other_changed(other_changed), .irq(irq));
    avi_src_model u_src (.pclk(pclk), .avi_valid(avi_valid), .avi_shape(avi_shape), .avi_scaling(avi_scaling),
        .avi_vfc(avi_vfc), .avi_prep(avi_prep), .avi_top(avi_top), .avi_bottom(avi_bottom),
        .avi_left(avi_left), .avi_right(avi_right), .other_changed(other_changed));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            $display("CHECK FAILED pready exp 1 got %b", pready);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [9:0] idx, input logic [31:0] e, input string nm);
        apb(1'b0, idx, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask
    task t_reset();
        rdchk(`AVI_IDX_FLAGS_A, 32'h0000_0000, "flags after reset");
        rdchk(`AVI_IDX_MASK, 32'h0000_0000, "mask after reset");
        `CHK("irq after reset", 1'b0, irq)
        apb(1'b0, 10'h3FF, 32'h0000_0000);
        `CHK("unmapped error", 1'b1, er)
        `CHK("unmapped data", 32'h0000_0000, rd)
    endtask
    task t_fields();
        for (int k = 0; k < 4; k++) begin
            u_src.send(4'h8 + 4'(k), 2'(k), 7'h10, 4'h9, 64'h1234_ABCD_0102_FEDC);
            rdchk(`AVI_IDX_SHAPE, 32'h8 + 32'(k), "shape code");
            rdchk(`AVI_IDX_SCALING, 32'(k), "scaling code");
        end
        u_src.send(4'hB, 2'h3, 7'h7F, 4'hA, 64'h1234_ABCD_0102_FEDC);
        rdchk(`AVI_IDX_VFC, 32'h0000_007F, "format code");
        rdchk(`AVI_IDX_PREP, 32'h0000_000A, "repetition");
        rdchk(`AVI_IDX_TOP_LO, 32'h34, "top low");
        rdchk(`AVI_IDX_TOP_HI, 32'h12, "top high");
        rdchk(`AVI_IDX_BOT_LO, 32'hCD, "bottom low");
        rdchk(`AVI_IDX_BOT_HI, 32'hAB, "bottom high");
        rdchk(`AVI_IDX_LEFT_LO, 32'h02, "left low");
        rdchk(`AVI_IDX_LEFT_HI, 32'h01, "left high");
        rdchk(`AVI_IDX_RIGHT_LO, 32'hDC, "right low");
        rdchk(`AVI_IDX_RIGHT_HI, 32'hFE, "right high");
    endtask
    task t_flags();
        apb(1'b0, `AVI_IDX_FLAGS_A, 32'h0);
        u_src.send(4'hB, 2'h3, 7'h7F, 4'hA, 64'h1234_ABCD_0102_FEDC);
        rdchk(`AVI_IDX_FLAGS_B, 32'h00, "same packet");
        u_src.send(4'hB, 2'h3, 7'h05, 4'hA, 64'h1234_ABCD_0102_FEDC);
        rdchk(`AVI_IDX_FLAGS_B, 32'h01, "changed packet");
        rdchk(`AVI_IDX_FLAGS_A, 32'h00, "flags after read");
        for (int k = 1; k < 7; k++) begin
            u_src.pulse(6'h01 << (k - 1));
            rdchk(k[0] ? `AVI_IDX_FLAGS_A : `AVI_IDX_FLAGS_B, 32'h1 << k, "flag position");
        end
        u_src.pulse(6'h3F);
        rdchk(`AVI_IDX_FLAGS_A, 32'h7E, "all other flags");
        rdchk(`AVI_IDX_FLAGS_B, 32'h00, "copy cleared");
    endtask
    task t_write();
        u_src.pulse(6'h01);
        apb(1'b1, `AVI_IDX_SCALING, 32'hFFFF_FFFF);
        apb(1'b1, `AVI_IDX_FLAGS_A, 32'h0000_0000);
        `CHK("write error", 1'b0, er)
        rdchk(`AVI_IDX_SCALING, 32'h3, "scaling after write");
        rdchk(`AVI_IDX_FLAGS_B, 32'h02, "flags after write");
    endtask
    task t_irq();
        apb(1'b0, `AVI_IDX_ISTAT, 32'h0);
        u_src.pulse(6'h01);
        repeat (3) @(posedge pclk);
        `CHK("masked irq", 1'b0, irq)
        rdchk(`AVI_IDX_ISTAT, 32'h02, "status sticky");
        apb(1'b1, `AVI_IDX_MASK, 32'h0000_0002);
        rdchk(`AVI_IDX_MASK, 32'h0000_0002, "mask readback");
        u_src.pulse(6'h01);
        repeat (3) @(posedge pclk);
        `CHK("unmasked irq", 1'b1, irq)
        rdchk(`AVI_IDX_ISTAT, 32'h02, "status read");
        repeat (2) @(posedge pclk);
        `CHK("irq after clear", 1'b0, irq)
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_flags();
        t_write();
        t_irq();
        stop_test();
    end
    initial begin
        #200us;
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
